// >>> design/acr_readout.sv
/*
 * acr_readout: conversion / sleep / data-output sequencer with a 32-bit
 * serial shift-out for a two-channel delta-sigma converter.
 * Assumes the analog core hands over a sample with done_i and that cs_n_i,
 * sck_in_i are synchronous to clk_i. The pad merges *_oe with *_o.
 */
// How it works
// - cs low in sleep enters data output
// - cs high before sck rise: sleep, keep data
// - cs high after sck rise: abort, convert
// - sdo changes on falling sck only
// - output ends after 32 bits or cs high
// - output word is the latest conversion
// - no config registers; pins pick modes
// - power-on reset clears state, selects channel 0
// - 32 bits msb first: status, result, sub-lsb
// - bit 31 live eoc while cs low
// - bit 30 gives converted channel
// - bit 29 sign, high for non-negative
// - bits 29/28 flag over and under range
// - bits 28..5 result, 4..0 sub-lsb
// - cs high: sdo floats, sck ignored
// - bit 30 on first fall, bit 0 31st
// - 32nd fall shows next eoc
// - channels alternate from channel 0
// - after conversion sleep while cs high
// - sck level at por/cs fall picks mode
// - internal sck is conversion clock over 8
`timescale 1ns/1ps
module acr_readout
    import acr_pkg::*;
#(
    parameter int unsigned CONV_CYCLES = acr_pkg::CONV_CYCLES_DEF,
    parameter int unsigned POR_LEN     = acr_pkg::POR_CYCLES
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 cs_n_i,
    input  wire logic                 sck_in_i,
    input  wire acr_pkg::acr_sample_t sample_i,
    input  wire logic                 done_i,
    input  wire logic                 notch_clock_select_pin_i,
    output logic                      sck_o,
    output logic                      sck_oe_o,
    output logic                      sdo_o,
    output logic                      sdo_oe_o,
    output logic                      start_conv_o,
    output logic                      conv_channel_o,
    output logic                      notch_sel_o,
    output logic                      int_sck_mode_o
);
    import acr_pkg::*;

    acr_state_t state;
    logic [31:0] por_cnt;
    logic        por_busy;
    logic [31:0] conv_cnt;
    logic [WORD_BITS-1:0] shreg;
    logic [5:0]  bit_cnt;
    logic        seen_rise;
    logic        cs_n_q;
    logic        sck_q;
    logic [2:0]  div_cnt;
    logic        sck_int;
    logic        chan;
    logic        eoc_n;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_rise;
    logic        cs_fall;
    logic        sck_now;
    logic        conv_done;
    logic        end_out;
    logic        next_sdo;

    // the live clock is the pad in external mode, our divider otherwise
    assign sck_now   = int_sck_mode_o ? sck_int : sck_in_i;
    assign sck_rise  = sck_now & ~sck_q;
    assign sck_fall  = ~sck_now & sck_q;
    assign cs_rise   = cs_n_i & ~cs_n_q;
    assign cs_fall   = ~cs_n_i & cs_n_q;
    // digital model: done after CONV_CYCLES or the core's strobe
    assign conv_done = (state == ACR_CONVERT) && !por_busy &&
                       ((conv_cnt >= CONV_CYCLES - 1) || done_i);
    assign end_out   = (state == ACR_OUTPUT) &&
                       ((cs_rise && seen_rise) ||
                        (sck_fall && bit_cnt == LAST_BIT_COUNT - 6'h01));

    // power-on reset stretch; core is held off until it runs out
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            por_cnt  <= 32'h0;
            por_busy <= 1'b1;
        end else if (por_busy) begin
            por_cnt  <= por_cnt + 32'h1;
            por_busy <= (por_cnt < POR_LEN - 1);
        end
    end

    // edge history of the pins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cs_n_q <= 1'b1;
            sck_q  <= 1'b0;
        end else begin
            cs_n_q <= cs_n_i;
            sck_q  <= sck_now;
        end
    end

    // cycle sequencer
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || por_busy) begin
            state <= ACR_CONVERT;
        end else begin
            case (state)
                ACR_CONVERT: begin
                    if (conv_done) begin
                        state <= ACR_SLEEP;
                    end
                end
                ACR_SLEEP: begin
                    if (!cs_n_i) begin
                        state <= ACR_OUTPUT;
                    end
                end
                ACR_OUTPUT: begin
                    if (end_out) begin
                        state <= ACR_CONVERT;
                    end else if (cs_n_i && !seen_rise) begin
                        state <= ACR_SLEEP;
                    end
                end
                default: begin
                    state <= ACR_CONVERT;
                end
            endcase
        end
    end

    // conversion timer; cleared outside the convert state, so it also counts through the power-on stretch
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || state != ACR_CONVERT) begin
            conv_cnt <= 32'h0;
        end else begin
            conv_cnt <= conv_cnt + 32'h1;
        end
    end

    // channel ping-pong: flip once per finished conversion
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || por_busy) begin
            chan <= 1'b0;
        end else if (conv_done) begin
            chan <= ~chan;
        end
    end

    // eoc flag goes low at completion, high again when a new one starts
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            eoc_n <= 1'b1;
        end else if (conv_done) begin
            eoc_n <= 1'b0;
        end else if (end_out) begin
            eoc_n <= 1'b1;
        end
    end

    // result word is latched straight from the conversion: no pipeline
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            shreg     <= '0;
            bit_cnt   <= 6'h0;
            seen_rise <= 1'b0;
        end else if (conv_done) begin
            shreg <= {1'b0, chan, sample_i.sign_bit, sample_i.result,
                      sample_i.sub_lsb};
            bit_cnt   <= 6'h0;
            seen_rise <= 1'b0;
        end else if (state == ACR_OUTPUT && !cs_n_i) begin
            // pulses with cs high never get here, so the word is kept
            if (sck_rise) begin
                seen_rise <= 1'b1;
            end
            if (sck_fall && seen_rise) begin
                shreg   <= {shreg[WORD_BITS-2:0], 1'b0};
                bit_cnt <= bit_cnt + 6'h01;
            end
        end else if (state != ACR_OUTPUT) begin
            seen_rise <= 1'b0;
            bit_cnt   <= 6'h0;
        end
    end

    // serial clock mode chosen from the pin during the power-on stretch and at cs fall outside output
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            int_sck_mode_o <= 1'b1;
        end else if (por_busy || (cs_fall && state != ACR_OUTPUT)) begin
            int_sck_mode_o <= sck_in_i;
        end
    end

    // internal sck divider, only runs while reading out
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || state != ACR_OUTPUT || !int_sck_mode_o || cs_n_i) begin
            div_cnt <= 3'h0;
            sck_int <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 3'h1;
            if (div_cnt == 3'(ISCK_DIV / 2 - 1)) begin
                div_cnt <= 3'h0;
                sck_int <= ~sck_int;
            end
        end
    end

    // bit shown on sdo: live eoc outside output and before the first shift, word msb after it
    always_comb begin
        if (state == ACR_OUTPUT && !end_out) begin
            next_sdo = (bit_cnt == 6'h0) ? eoc_n : shreg[BIT_EOC];
        end else begin
            next_sdo = (state == ACR_CONVERT || end_out) ? 1'b1 : eoc_n;
        end
    end

    // pad registers; no configuration registers exist, only pin timing
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sdo_o          <= 1'b1;
            sdo_oe_o       <= 1'b0;
            sck_o          <= 1'b1;
            sck_oe_o       <= 1'b0;
            start_conv_o   <= 1'b0;
            conv_channel_o <= 1'b0;
            notch_sel_o    <= 1'b0;
        end else begin
            sdo_o          <= next_sdo;
            sdo_oe_o       <= ~cs_n_i;
            sck_o          <= sck_int;
            sck_oe_o       <= int_sck_mode_o && state == ACR_OUTPUT && !cs_n_i;
            start_conv_o   <= end_out || (por_busy && por_cnt == POR_LEN - 1);
            conv_channel_o <= chan;
            notch_sel_o    <= notch_clock_select_pin_i;
        end
    end

    // steps of a readout used by the word-end and internal clock period properties
    sequence s_last_fall;
        state == ACR_OUTPUT && !cs_n_i && sck_fall && seen_rise &&
            bit_cnt == LAST_BIT_COUNT - 6'h01;
    endsequence

    sequence s_restarted;
        state == ACR_CONVERT && start_conv_o && sdo_o;
    endsequence

    sequence s_isck_rise;
        int_sck_mode_o && state == ACR_OUTPUT && !cs_n_i && sck_rise;
    endsequence

    sequence s_isck_hold;
        int_sck_mode_o && state == ACR_OUTPUT && !cs_n_i && !sck_fall;
    endsequence

    AST_SLEEP_ON_DONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        conv_done |=> state == ACR_SLEEP)
        else $error("no sleep after conversion");
    AST_WAKE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == ACR_SLEEP && !cs_n_i |=> state == ACR_OUTPUT)
        else $error("cs low did not wake");
    AST_KEEP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == ACR_OUTPUT && cs_n_i && !seen_rise
        |=> state == ACR_SLEEP && $stable(shreg))
        else $error("early cs rise lost data");
    AST_ABORT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == ACR_OUTPUT && seen_rise && cs_rise |=> state == ACR_CONVERT)
        else $error("abort did not restart");
    AST_FLOAT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cs_n_i |=> !sdo_oe_o)
        else $error("sdo driven with cs high");
    AST_CHAN_FLIP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        conv_done |=> chan != $past(chan))
        else $error("channel did not alternate");
    AST_CHAN_BIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        conv_done |=> shreg[BIT_CHAN] == $past(chan))
        else $error("channel bit wrong");
    AST_EOC_LOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == ACR_SLEEP && !cs_n_i |=> !sdo_o)
        else $error("eoc not low in sleep");
    AST_SHIFT_FALL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == ACR_OUTPUT && !sck_fall && !conv_done |=> $stable(shreg))
        else $error("shift off falling edge");
    AST_POR_CH0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        por_busy |=> !chan && state == ACR_CONVERT)
        else $error("por state wrong");

    // 32nd fall closes the word, restarts and shows the next flag
    AST_WORD_END: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_last_fall |=> s_restarted)
        else $error("word end did not restart");

    // an abort must also launch the next conversion
    AST_ABORT_START: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == ACR_OUTPUT && seen_rise && cs_rise |=> start_conv_o && sdo_o)
        else $error("abort gave no start");

    // each armed fall moves the word by exactly one place
    AST_SHIFT_ONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == ACR_OUTPUT && !cs_n_i && sck_fall && seen_rise && !end_out
        |=> shreg == {$past(shreg[WORD_BITS-2:0]), 1'b0} &&
            bit_cnt == $past(bit_cnt) + 6'h01)
        else $error("shift step wrong");

    // once shifting, the pad shows the word msb
    AST_SDO_BIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == ACR_OUTPUT && bit_cnt != 6'h0 && !end_out
        |=> sdo_o == $past(shreg[BIT_EOC]))
        else $error("sdo not word msb");

    // before the first shift the pad shows the done flag
    AST_FIRST_BIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == ACR_OUTPUT && bit_cnt == 6'h0 && !end_out
        |=> sdo_o == $past(eoc_n))
        else $error("first bit not the flag");

    // internal clock half period is four system clocks
    AST_ISCK_DIV: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_isck_rise ##1 s_isck_hold [*3] |=> sck_fall)
        else $error("internal sck period wrong");

    // mode latched from the pad level at a select fall
    AST_MODE_PICK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !por_busy && cs_fall && state != ACR_OUTPUT
        |=> int_sck_mode_o == $past(sck_in_i))
        else $error("sck mode not picked");

    // deselected sleep lasts as long as select stays high
    AST_SLEEP_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == ACR_SLEEP && cs_n_i |=> state == ACR_SLEEP)
        else $error("left sleep with cs high");

    // internal mode drives our divided clock onto the pad
    AST_SCK_DRIVE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        int_sck_mode_o && state == ACR_OUTPUT && !cs_n_i
        |=> sck_oe_o && sck_o == $past(sck_int))
        else $error("internal sck not driven");

    // no early finish while the timer runs and no strobe came
    AST_CONV_TIME: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state == ACR_CONVERT && !por_busy && conv_cnt < CONV_CYCLES - 1 && !done_i
        |=> state == ACR_CONVERT)
        else $error("conversion ended early");
endmodule

// >>> design/acr_pkg.sv
/*
 * acr_pkg: shared constants and types for the two-channel converter control
 * and serial readout block.
 * Assumes a single 25 MHz system clock; all pins are sampled synchronously.
 */
package acr_pkg;
    localparam int unsigned CLK_HZ           = 25_000_000;
    localparam int unsigned POR_TIME_US      = 1000;
    localparam int unsigned POR_CYCLES       = (CLK_HZ / 1_000_000) * POR_TIME_US;
    localparam int unsigned CONV_CYCLES_DEF  = 5000;
    localparam int unsigned ISCK_DIV         = 8;
    localparam int unsigned WORD_BITS        = 32;
    localparam int unsigned RESULT_BITS      = 24;
    localparam int unsigned SUB_BITS         = 5;
    localparam logic [4:0]  BIT_EOC          = 5'h1F;
    localparam logic [4:0]  BIT_CHAN         = 5'h1E;
    localparam logic [4:0]  BIT_SIGN         = 5'h1D;
    localparam logic [4:0]  BIT_MSB          = 5'h1C;
    localparam logic [5:0]  LAST_BIT_COUNT   = 6'h20;

    // one-hot cycle states
    typedef enum logic [2:0] {
        ACR_CONVERT = 3'h1,
        ACR_SLEEP   = 3'h2,
        ACR_OUTPUT  = 3'h4
    } acr_state_t;

    // one finished conversion from the analog core
    typedef struct packed {
        logic                   sign_bit;
        logic [RESULT_BITS-1:0] result;
        logic [SUB_BITS-1:0]    sub_lsb;
    } acr_sample_t;

    // two-signal (o, oe) output view of a two-way pin
    typedef struct packed {
        logic o;
        logic oe;
    } acr_pin_out_t;
endpackage

// >>> sim/acr_host_model.sv
/*
 * acr_host_model: serial host that drives chip select and, in external mode,
 * the serial clock; it samples the data line on each rising clock.
 * Assumes the bench merges all pad drivers into the two line inputs.
 */
`timescale 1ns/1ps
module acr_host_model (
    input  wire logic clk_i,
    input  wire logic sck_line_i,
    input  wire logic sdo_line_i,
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      timeout_o
);
    logic ext_q;
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        timeout_o = 1'b0;
        ext_q = 1'b1;
    end
    // clock level set before the select edge picks the mode
    task automatic select(input logic idle, output logic first);
        int k;
        sck_o = idle;
        ext_q = ~idle;
        @(negedge clk_i) cs_n_o = 1'b0;
        repeat (3) @(negedge clk_i);
        first = sdo_line_i;
        for (k = 0; k < 200 && sdo_line_i !== 1'b0; k++) @(negedge clk_i);
        if (k == 200) timeout_o = 1'b1;
    endtask
    task automatic deselect();
        @(negedge clk_i) cs_n_o = 1'b1;
    endtask
    // pulses while deselected; the device must not shift on them
    task automatic stray(input int n);
        repeat (2 * n) @(negedge clk_i) sck_o = ~sck_o;
    endtask
    // msb first, sampled at each rising clock, never on the fall
    task automatic xfer(input int n, output logic [31:0] w);
        int k;
        w = 32'h0;
        repeat (n) begin
            if (ext_q) begin
                repeat (4) @(negedge clk_i);
                sck_o = 1'b1;
            end else begin
                for (k = 0; k < 40 && sck_line_i !== 1'b0; k++) @(negedge clk_i);
                for (k = 0; k < 40 && sck_line_i !== 1'b1; k++) @(negedge clk_i);
                if (k == 40) timeout_o = 1'b1;
            end
            w = {w[30:0], sdo_line_i};
            if (ext_q) begin
                repeat (4) @(negedge clk_i);
                sck_o = 1'b0;
            end
        end
    endtask
endmodule

// >>> sim/acr_readout_tb.sv
/*
 * acr_readout_tb: readouts in both clock modes, deselect before and after
 * the first clock rise, stray clocks while deselected.
 * Assumes the design assertions run alongside; the core is a fixed table.
 */
`timescale 1ns/1ps
module acr_readout_tb;
    import acr_pkg::*;
    localparam int unsigned CONV = 50;
    localparam int unsigned POR  = 10;
    logic        clk, rst_n, notch, cs_n, host_sck, tmo, first;
    logic        sck, sck_oe, sdo, sdo_oe, sdo_last;
    logic        start_conv, conv_ch, notch_sel, int_mode;
    logic [31:0] w;
    acr_sample_t smp;
    acr_sample_t tbl [4];
    int          err_count, cmp_count, starts, s0;
    // a released data line shows the inverse of its last value
    wire sck_line = sck_oe ? sck : host_sck;
    wire sdo_line = sdo_oe ? sdo : ~sdo_last;

    acr_readout #(.CONV_CYCLES(CONV), .POR_LEN(POR)) i_dut (
        .clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sck_in_i(sck_line),
        .sample_i(smp), .done_i(1'b0), .notch_clock_select_pin_i(notch),
        .sck_o(sck), .sck_oe_o(sck_oe), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
        .start_conv_o(start_conv), .conv_channel_o(conv_ch),
        .notch_sel_o(notch_sel), .int_sck_mode_o(int_mode));
    acr_host_model i_host (.clk_i(clk), .sck_line_i(sck_line), .sdo_line_i(sdo_line),
        .cs_n_o(cs_n), .sck_o(host_sck), .timeout_o(tmo));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // conversion starts are counted, not sampled, since they are pulses
    always @(posedge clk) begin
        if (sdo_oe) sdo_last <= sdo;
        if (start_conv === 1'b1) starts <= starts + 1;
    end
    always @(posedge tmo) begin
        err_count++;
        end_of_test();
    end

    task automatic chk_bit(input string name, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %0b seen %0b", name, exp, got);
        end
    endtask
    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // whole word, then the next flag and exactly one new conversion
    task automatic full_read(input logic idle, input logic ch, input acr_sample_t s);
        i_host.select(idle, first);
        s0 = starts;
        i_host.xfer(32, w);
        chk_word("word", {1'b0, ch, s}, w);
        repeat (6) @(negedge clk);
        chk_bit("flag after word", 1'b1, sdo_line);
        chk_bit("restart", 1'b1, starts == s0 + 1);
        i_host.deselect();
    endtask

    initial begin
        tbl[0] = {1'b1, 24'h3A5C96, 5'h15};
        tbl[1] = {1'b1, 24'h800000, 5'h00}; // over range
        tbl[2] = {1'b0, 24'h7FFFFF, 5'h1F}; // under range
        tbl[3] = {1'b0, 24'hC00001, 5'h0A};
        rst_n = 1'b0;
        notch = 1'b1;
        smp = tbl[0];
        sdo_last = 1'b0;
        err_count = 0;
        cmp_count = 0;
        starts = 0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (POR + 4) @(negedge clk);
        chk_bit("channel", 1'b0, conv_ch);
        chk_bit("sdo enable", 1'b0, sdo_oe);
        chk_bit("clock mode", 1'b0, int_mode);
        chk_bit("notch copy", 1'b1, notch_sel);
        chk_bit("first start", 1'b1, starts == 1);
        full_read(1'b0, 1'b0, tbl[0]);
        chk_bit("flag converting", 1'b1, first);
        smp = tbl[1];
        repeat (CONV + 20) @(negedge clk);
        i_host.stray(3);
        i_host.select(1'b0, first);
        chk_bit("flag sleeping", 1'b0, first);
        s0 = starts;
        i_host.deselect();
        repeat (4) @(negedge clk);
        chk_bit("no restart", 1'b1, starts == s0);
        full_read(1'b0, 1'b1, tbl[1]);
        smp = tbl[2];
        i_host.select(1'b0, first);
        i_host.xfer(5, w);
        chk_word("partial", {27'h0, 2'h0, tbl[2][29:27]}, w);
        s0 = starts;
        i_host.deselect();
        repeat (4) @(negedge clk);
        chk_bit("abort restart", 1'b1, starts == s0 + 1);
        smp = tbl[3];
        full_read(1'b1, 1'b1, tbl[3]);
        chk_bit("clock mode", 1'b1, int_mode);
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        end_of_test();
    end
endmodule
